// [rtl/plt_logic_tile.v]
// logic tile: product-term array, or array, sixteen macrocells and configuration port
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/10ps
`include "plt_map.vh"
// Overview of operation
// [R1] sixteen macrocells built from forty routed tile inputs
// [R2] fifty-six product terms, each an and of chosen inputs or complements
// [R3] every product term can reach the or gate of every macrocell
// [R4] one sum of products may use any number of terms, all 56
// [R5] one product term may feed all sixteen or gates at once
// [R6] macrocells sharing terms still pick their own clock, set, reset, enable
// [R7] optional xor of the sum with one separately chosen product term
// [R8] selectable inversion of the combined logic result
// [R9] output combinational, or stored in d flop, t flop or latch
// [R10] clock, set, reset, enable each from global, tile or local term
// [R11] storage updates on one clock edge or on both edges
// [R12] active edge or latch enable level chosen per macrocell
// [R13] d flop has optional clock enable that holds the value
// [R14] tile shared control terms for clock, set, reset and output enable
// [R15] storage may capture own pin and drive the routing matrix
// [R16] logic stays usable as buried node while storage is input register
// [R17] macrocell results and pin inputs go back to the routing matrix
// [R18] t flop inverts on active edge when input high, else holds
// [R19] asserted set or reset forces storage at once, ignoring clock and enable
module plt_logic_tile (
  input wire core_clk,
  input wire arst_n,
  input wire [9:0] cfg_addr,
  input wire [31:0] cfg_wdata,
  input wire cfg_wr,
  input wire cfg_rd,
  output reg [31:0] cfg_rdata_ff,
  input wire [39:0] route_in,
  input wire [2:0] gclk,
  input wire g_set,
  input wire g_rst,
  input wire [1:0] goe,
  input wire [15:0] pad_in,
  output wire [15:0] pad_out,
  output wire [15:0] pad_oe_n,
  output wire [15:0] mc_route_out,
  output wire [15:0] inreg_route_out,
  output wire [15:0] pin_route_out
);
  // ------------------------------------------------------------
  // configuration storage
  // ------------------------------------------------------------
  // bits 39:0 select true inputs, bits 79:40 select complements
  reg [79:0] and_row_ff [0:55];
  reg [55:0] or_row_ff [0:15];
  reg [30:0] mc_cfg0_ff [0:15];
  reg [23:0] mc_cfg1_ff [0:15];
  reg [23:0] tile_ctrl_ff;
  reg [31:0] rd_mux;
  wire [55:0] pt;
  wire [15:0] pin_sync;
  wire [15:0] store_q;
  wire [79:0] literal = {~route_in, route_in};
  integer i;
  genvar gp;
  genvar gm;

  // out-of-range term indices give a constant low instead of an unknown
  function pick;
    input [55:0] terms;
    input [5:0] idx;
    begin
      pick = (idx < `PLT_PT_LIMIT) ? terms[idx] : 1'b0;
    end
  endfunction

  // ------------------------------------------------------------
  // and array
  // ------------------------------------------------------------
  generate
    for (gp = 0; gp < `PLT_NUM_PT; gp = gp + 1) begin : g_pt
      // an empty row is all don't-care and reads high
      assign pt[gp] = &(~and_row_ff[gp] | literal); // see [R1] [R2]
    end
  endgenerate

  // ------------------------------------------------------------
  // tile shared control terms
  // ------------------------------------------------------------
  wire shared_clock_term = pick(pt, tile_ctrl_ff[`PLT_F_TC_CLK]); // see [R14]
  wire shared_async_set_term = pick(pt, tile_ctrl_ff[`PLT_F_TC_SET]); // see [R14]
  wire shared_async_reset_term = pick(pt, tile_ctrl_ff[`PLT_F_TC_RST]); // see [R14]
  wire shared_output_enable_term = pick(pt, tile_ctrl_ff[`PLT_F_TC_OE]); // see [R14]

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  wire [5:0] pidx = cfg_addr[7:2];
  wire [1:0] wsel = cfg_addr[1:0];
  wire [3:0] midx = cfg_addr[4:1];
  wire and_hit = ((cfg_addr & `PLT_ADDR_AND_MASK) == `PLT_ADDR_AND_BASE)
                 & (pidx < `PLT_PT_LIMIT) & (wsel != 2'h3);
  wire or_hit = (cfg_addr & `PLT_ADDR_REGION_MASK) == `PLT_ADDR_OR_BASE;
  wire mc_hit = (cfg_addr & `PLT_ADDR_REGION_MASK) == `PLT_ADDR_MC_BASE;
  wire tile_hit = cfg_addr == `PLT_ADDR_TILE_CTRL;

  // ------------------------------------------------------------
  // configuration writes
  // ------------------------------------------------------------
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (i = 0; i < `PLT_NUM_PT; i = i + 1) begin
        and_row_ff[i] <= `PLT_RST_AND;
      end
      for (i = 0; i < `PLT_NUM_MC; i = i + 1) begin
        or_row_ff[i] <= `PLT_RST_OR;
        mc_cfg0_ff[i] <= `PLT_RST_CFG0;
        mc_cfg1_ff[i] <= `PLT_RST_CFG1;
      end
      tile_ctrl_ff <= `PLT_RST_TILE;
    end else if (cfg_wr) begin
      if (and_hit) begin
        case (wsel)
          2'h0: begin
            and_row_ff[pidx][31:0] <= cfg_wdata;
          end
          2'h1: begin
            and_row_ff[pidx][63:32] <= cfg_wdata;
          end
          default: begin
            and_row_ff[pidx][79:64] <= cfg_wdata[15:0];
          end
        endcase
      end else if (or_hit) begin
        // any term may be set in any or row, so terms are freely shared
        if (cfg_addr[0]) begin
          or_row_ff[midx][55:32] <= cfg_wdata[23:0]; // see [R3] [R5]
        end else begin
          or_row_ff[midx][31:0] <= cfg_wdata; // see [R3] [R5]
        end
      end else if (mc_hit) begin
        if (cfg_addr[0]) begin
          mc_cfg1_ff[midx] <= cfg_wdata[23:0];
        end else begin
          mc_cfg0_ff[midx] <= cfg_wdata[30:0];
        end
      end else if (tile_hit) begin
        tile_ctrl_ff <= cfg_wdata[23:0];
      end
    end
  end

  // ------------------------------------------------------------
  // configuration and status reads
  // ------------------------------------------------------------
  always @* begin
    rd_mux = 32'h0;
    if (and_hit) begin
      case (wsel)
        2'h0: begin
          rd_mux = and_row_ff[pidx][31:0];
        end
        2'h1: begin
          rd_mux = and_row_ff[pidx][63:32];
        end
        default: begin
          rd_mux = {16'h0, and_row_ff[pidx][79:64]};
        end
      endcase
    end else if (or_hit) begin
      if (cfg_addr[0]) begin
        rd_mux = {8'h0, or_row_ff[midx][55:32]};
      end else begin
        rd_mux = or_row_ff[midx][31:0];
      end
    end else if (mc_hit) begin
      if (cfg_addr[0]) begin
        rd_mux = {8'h0, mc_cfg1_ff[midx]};
      end else begin
        rd_mux = {1'h0, mc_cfg0_ff[midx]};
      end
    end else if (tile_hit) begin
      rd_mux = {8'h0, tile_ctrl_ff};
    end else if (cfg_addr == `PLT_ADDR_STAT_OUT) begin
      rd_mux = {store_q, mc_route_out};
    end else if (cfg_addr == `PLT_ADDR_STAT_PIN) begin
      rd_mux = {pin_sync, inreg_route_out};
    end else if (cfg_addr == `PLT_ADDR_STAT_PT_LO) begin
      rd_mux = pt[31:0];
    end else if (cfg_addr == `PLT_ADDR_STAT_PT_HI) begin
      rd_mux = {4'h0, shared_output_enable_term, shared_async_reset_term,
                shared_async_set_term, shared_clock_term, pt[55:32]};
    end
  end

  // read data stand for one cycle only and are zero otherwise
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_rdata_ff <= 32'h0;
    end else if (cfg_rd) begin
      cfg_rdata_ff <= rd_mux;
    end else begin
      cfg_rdata_ff <= 32'h0;
    end
  end

  // ------------------------------------------------------------
  // pin inputs
  // ------------------------------------------------------------
  plt_pin_sync #(
    .WIDTH(16)
  ) u_pin_sync (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .pin_raw(pad_in),
    .pin_ff(pin_sync)
  );

  assign pin_route_out = pin_sync; // see [R17]

  // ------------------------------------------------------------
  // macrocells
  // ------------------------------------------------------------
  generate
    for (gm = 0; gm < `PLT_NUM_MC; gm = gm + 1) begin : g_mc
      wire [30:0] c0 = mc_cfg0_ff[gm];
      wire [23:0] c1 = mc_cfg1_ff[gm];
      wire [3:0] gclk_ext = {1'b0, gclk};
      wire sop = |(or_row_ff[gm] & pt); // see [R3] [R4] [R5]
      wire xor_term = pick(pt, c0[`PLT_F_XOR_PT]); // see [R7]
      wire ce_sig = pick(pt, c1[`PLT_F_CE_PT]);
      reg clk_sig;
      reg set_sig;
      reg rst_sig;
      reg oe_sig;

      // each control is chosen on its own, so sharing terms costs no freedom
      always @* begin
        case (c0[`PLT_F_CLK_SRC]) // see [R6] [R10]
          `PLT_SRC_GLOBAL: clk_sig = gclk_ext[c0[`PLT_F_GCLK_IDX]];
          `PLT_SRC_TILE: clk_sig = shared_clock_term;
          `PLT_SRC_LOCAL: clk_sig = pick(pt, c0[`PLT_F_CLK_PT]);
          default: clk_sig = 1'b0;
        endcase
        case (c0[`PLT_F_SET_SRC]) // see [R6] [R10]
          `PLT_SRC_GLOBAL: set_sig = g_set;
          `PLT_SRC_TILE: set_sig = shared_async_set_term;
          `PLT_SRC_LOCAL: set_sig = pick(pt, c1[`PLT_F_SET_PT]);
          default: set_sig = 1'b0;
        endcase
        case (c0[`PLT_F_RST_SRC]) // see [R6] [R10]
          `PLT_SRC_GLOBAL: rst_sig = g_rst;
          `PLT_SRC_TILE: rst_sig = shared_async_reset_term;
          `PLT_SRC_LOCAL: rst_sig = pick(pt, c1[`PLT_F_RST_PT]);
          default: rst_sig = 1'b0;
        endcase
        case (c0[`PLT_F_OE_SRC]) // see [R6] [R10]
          `PLT_SRC_GLOBAL: oe_sig = goe[c0[`PLT_F_GOE_IDX]];
          `PLT_SRC_TILE: oe_sig = shared_output_enable_term;
          `PLT_SRC_LOCAL: oe_sig = pick(pt, c1[`PLT_F_OE_PT]);
          default: oe_sig = 1'b0;
        endcase
      end

      plt_macrocell u_mc (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .mode(c0[`PLT_F_MODE]),
        .xor_en(c0[`PLT_F_XOR_EN]),
        .invert(c0[`PLT_F_INVERT]),
        .both_edge(c0[`PLT_F_BOTH_EDGE]),
        .clk_pol(c0[`PLT_F_CLK_POL]),
        .ce_en(c0[`PLT_F_CE_EN]),
        .input_reg(c0[`PLT_F_INREG]),
        .sop(sop),
        .xor_term(xor_term),
        .clk_sig(clk_sig),
        .ce_sig(ce_sig),
        .set_sig(set_sig),
        .rst_sig(rst_sig),
        .pin_in(pin_sync[gm]),
        .route_out(mc_route_out[gm]),
        .inreg_out(inreg_route_out[gm]),
        .pad_out(pad_out[gm]),
        .store_q(store_q[gm])
      );

      // a pin used as input register is never driven by its own macrocell
      assign pad_oe_n[gm] = ~(oe_sig & ~c0[`PLT_F_INREG]); // see [R15]
    end
  endgenerate
endmodule // plt_logic_tile

// [rtl/plt_map.vh]
// address map, field positions, reset values and sizes of the logic tile
`ifndef PLT_MAP_VH
`define PLT_MAP_VH
// ------------------------------------------------------------
// sizes
// ------------------------------------------------------------
`define PLT_NUM_MC 16
`define PLT_NUM_IN 40
`define PLT_NUM_PT 56
`define PLT_PT_LIMIT 6'h38
// ------------------------------------------------------------
// word addresses on the configuration port
// ------------------------------------------------------------
`define PLT_ADDR_AND_BASE 10'h000
`define PLT_ADDR_AND_MASK 10'h300
`define PLT_ADDR_OR_BASE 10'h100
`define PLT_ADDR_MC_BASE 10'h140
`define PLT_ADDR_REGION_MASK 10'h3E0
`define PLT_ADDR_TILE_CTRL 10'h160
`define PLT_ADDR_STAT_OUT 10'h161
`define PLT_ADDR_STAT_PIN 10'h162
`define PLT_ADDR_STAT_PT_LO 10'h163
`define PLT_ADDR_STAT_PT_HI 10'h164
// ------------------------------------------------------------
// macrocell word 0 / word 1 and tile control fields
// ------------------------------------------------------------
`define PLT_F_XOR_EN 0
`define PLT_F_INVERT 1
`define PLT_F_MODE 3:2
`define PLT_F_BOTH_EDGE 4
`define PLT_F_CLK_POL 5
`define PLT_F_CE_EN 6
`define PLT_F_INREG 7
`define PLT_F_CLK_SRC 9:8
`define PLT_F_GCLK_IDX 11:10
`define PLT_F_SET_SRC 13:12
`define PLT_F_RST_SRC 15:14
`define PLT_F_OE_SRC 17:16
`define PLT_F_GOE_IDX 18
`define PLT_F_XOR_PT 24:19
`define PLT_F_CLK_PT 30:25
`define PLT_F_SET_PT 5:0
`define PLT_F_RST_PT 11:6
`define PLT_F_OE_PT 17:12
`define PLT_F_CE_PT 23:18
`define PLT_F_TC_CLK 5:0
`define PLT_F_TC_SET 11:6
`define PLT_F_TC_RST 17:12
`define PLT_F_TC_OE 23:18
// ------------------------------------------------------------
// encodings and reset values
// ------------------------------------------------------------
`define PLT_MODE_COMB 2'h0
`define PLT_MODE_D 2'h1
`define PLT_MODE_T 2'h2
`define PLT_MODE_LATCH 2'h3
`define PLT_SRC_NONE 2'h0
`define PLT_SRC_GLOBAL 2'h1
`define PLT_SRC_TILE 2'h2
`define PLT_SRC_LOCAL 2'h3
`define PLT_RST_AND 80'h0
`define PLT_RST_OR 56'h0
`define PLT_RST_CFG0 31'h0
`define PLT_RST_CFG1 24'h0
`define PLT_RST_TILE 24'h0
`endif

// [rtl/plt_pin_sync.v]
// three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
module plt_pin_sync #(
  parameter WIDTH = 16
) (
  input wire core_clk,
  input wire arst_n,
  input wire [WIDTH-1:0] pin_raw,
  output reg [WIDTH-1:0] pin_ff
);
  reg [WIDTH-1:0] s1_ff;
  reg [WIDTH-1:0] s2_ff;
  reg [WIDTH-1:0] s3_ff;
  integer i;
  // s1 feeds s2 only; the agreement test looks at s2 and s3
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_ff <= {WIDTH{1'b0}};
      s2_ff <= {WIDTH{1'b0}};
      s3_ff <= {WIDTH{1'b0}};
      pin_ff <= {WIDTH{1'b0}};
    end else begin
      s1_ff <= pin_raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (s2_ff[i] == s3_ff[i]) begin
          pin_ff[i] <= s3_ff[i];
        end
      end
    end
  end
endmodule // plt_pin_sync

// [rtl/plt_macrocell.v]
// one macrocell: xor and polarity stage, storage element and output selection
`timescale 1ns/10ps
`include "plt_map.vh"
module plt_macrocell (
  input wire core_clk,
  input wire arst_n,
  input wire [1:0] mode,
  input wire xor_en,
  input wire invert,
  input wire both_edge,
  input wire clk_pol,
  input wire ce_en,
  input wire input_reg,
  input wire sop,
  input wire xor_term,
  input wire clk_sig,
  input wire ce_sig,
  input wire set_sig,
  input wire rst_sig,
  input wire pin_in,
  output wire route_out,
  output wire inreg_out,
  output wire pad_out,
  output wire store_q
);
  reg q_ff;
  reg clk_prev_ff;
  reg nxt_q;
  wire comb = (sop ^ (xor_en & xor_term)) ^ invert; // see [R7] [R8]
  wire d_in = input_reg ? pin_in : comb; // see [R15]
  wire rise = clk_sig & ~clk_prev_ff;
  wire fall = ~clk_sig & clk_prev_ff;
  wire edge_hit = both_edge ? (rise | fall) : (clk_pol ? fall : rise); // see [R11] [R12]
  wire latch_open = clk_sig ^ clk_pol; // see [R12]
  wire latch_pass = (mode == `PLT_MODE_LATCH) & latch_open;
  // set and reset override the stored value at once, not only at the next edge
  wire q_view = rst_sig ? 1'b0 : (set_sig ? 1'b1 : (latch_pass ? d_in : q_ff)); // see [R19]
  wire result = (mode == `PLT_MODE_COMB) ? comb : q_view; // see [R9]

  always @* begin
    nxt_q = q_ff;
    case (mode)
      `PLT_MODE_D: begin
        if (edge_hit & (~ce_en | ce_sig)) nxt_q = d_in; // see [R13]
      end
      `PLT_MODE_T: begin
        if (edge_hit & d_in) nxt_q = ~q_ff; // see [R18]
      end
      `PLT_MODE_LATCH: begin
        if (latch_open) nxt_q = d_in;
      end
      default: begin
        nxt_q = q_ff;
      end
    endcase
    // reset wins over set when both are asserted
    if (set_sig) nxt_q = 1'b1; // see [R19]
    if (rst_sig) nxt_q = 1'b0; // see [R19]
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      q_ff <= 1'b0;
      clk_prev_ff <= 1'b0;
    end else begin
      q_ff <= nxt_q;
      clk_prev_ff <= clk_sig;
    end
  end

  assign pad_out = result;
  assign route_out = input_reg ? comb : result; // see [R16] [R17]
  assign inreg_out = input_reg ? q_view : 1'b0; // see [R15]
  assign store_q = q_ff;
endmodule // plt_macrocell

// [verif/plt_route_model.sv]
// routing matrix and pin model facing the logic tile
`timescale 1ns/10ps
module plt_route_model (
  input logic [23:0] route_drv,
  input logic [15:0] pad_drv,
  input logic [15:0] pad_out,
  input logic [15:0] pad_oe_n,
  input logic [15:0] pin_route_out,
  output logic [39:0] route_in,
  output logic [15:0] pad_in
);
  // synchronised pins circulate back on the low inputs, so no loop can form
  assign route_in = {route_drv, pin_route_out};
  // the pin shows the tile's level wherever its enable is low
  assign pad_in = (pad_out & ~pad_oe_n) | (pad_drv & pad_oe_n);
endmodule // plt_route_model

// [verif/plt_tile_checker.sv]
// concurrent checks on the logic tile ports and their bind
`timescale 1ns/10ps
module plt_tile_checker (
  input logic core_clk,
  input logic arst_n,
  input logic [9:0] cfg_addr,
  input logic [31:0] cfg_wdata,
  input logic cfg_wr,
  input logic cfg_rd,
  input logic [31:0] cfg_rdata_ff,
  input logic [2:0] gclk,
  input logic g_rst,
  input logic [1:0] goe,
  input logic [15:0] pad_in,
  input logic [15:0] pad_oe_n,
  input logic [15:0] mc_route_out,
  input logic [15:0] inreg_route_out,
  input logic [15:0] pin_route_out
);
  // only macrocell 0 word 0 is shadowed; the cell checks judge macrocell 0, the read and pin checks all sixteen bits
  logic [30:0] mc0_ff;
  logic [3:0] up_ff;
  logic gsel;
  logic dr;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mc0_ff <= 31'h0;
      up_ff <= 4'h0;
    end else begin
      if (cfg_wr && cfg_addr == 10'h140) begin
        mc0_ff <= cfg_wdata[30:0];
      end
      if (up_ff != 4'h8) begin
        up_ff <= up_ff + 4'h1;
      end
    end
  end
  assign gsel = gclk[mc0_ff[11:10] == 2'h3 ? 2'h0 : mc0_ff[11:10]];
  // plain rising d flop on global clock 0, no set, reset or enable
  assign dr = mc0_ff[3:2] == 2'h1 && mc0_ff[15:8] == 8'h01 && mc0_ff[7:4] == 4'h0;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence s_rd(a);
    cfg_rd && cfg_addr == a;
  endsequence
  sequence s_pin_quiet;
    (up_ff == 4'h8 && $stable(pad_in)) [*5];
  endsequence
  a_rdata_idle: assert property (
    !cfg_rd |=> cfg_rdata_ff == 32'h0)
    else $error("read data not zero outside a read");
  a_status_out_view: assert property (
    s_rd(10'h161) |=> cfg_rdata_ff[15:0] == $past(mc_route_out))
    else $error("status word differs from results");
  a_pin_follow: assert property (
    s_pin_quiet |-> pin_route_out == pad_in)
    else $error("pin feedback does not follow quiet pins");
  a_oe_off: assert property (
    mc0_ff[17:16] == 2'h0 || (mc0_ff[7] && mc0_ff[2]) |-> pad_oe_n[0])
    else $error("pin driven without enable");
  a_oe_global: assert property (
    mc0_ff[17:16] == 2'h1 && !mc0_ff[7] |-> pad_oe_n[0] == !goe[mc0_ff[18]])
    else $error("pin enable not from global enable");
  a_inreg_zero: assert property (
    !mc0_ff[7] |-> inreg_route_out[0] == 1'b0)
    else $error("input register output set while unused");
  a_d_hold_edge: assert property (
    dr && $stable(mc0_ff) && !$rose(gsel) && !(cfg_wr && cfg_addr == 10'h140)
    |=> $stable(mc_route_out[0]))
    else $error("d flop changed without rising edge");
  a_rst_force: assert property (
    mc0_ff[3:2] != 2'h0 && mc0_ff[15:14] == 2'h1 && !mc0_ff[7] && !mc0_ff[1] && g_rst
    |-> mc_route_out[0] == 1'b0)
    else $error("reset does not clear storage at once");
endmodule // plt_tile_checker

bind plt_logic_tile plt_tile_checker u_chk (.core_clk(core_clk), .arst_n(arst_n),
  .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
  .cfg_rdata_ff(cfg_rdata_ff), .gclk(gclk), .g_rst(g_rst), .goe(goe), .pad_in(pad_in),
  .pad_oe_n(pad_oe_n), .mc_route_out(mc_route_out), .inreg_route_out(inreg_route_out),
  .pin_route_out(pin_route_out));

// [verif/plt_logic_tile_tb.sv]
// self-checking bench for the logic tile
`timescale 1ns/10ps
module plt_logic_tile_tb;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [9:0] cfg_addr = 10'h0;
  logic [31:0] cfg_wdata = 32'h0;
  logic cfg_wr = 1'b0;
  logic cfg_rd = 1'b0;
  logic [23:0] rt = 24'h0;
  logic [2:0] gclk = 3'h0;
  logic g_set = 1'b0;
  logic g_rst = 1'b0;
  logic [1:0] goe = 2'h0;
  logic [15:0] pad_drv = 16'h0;
  wire [31:0] cfg_rdata_ff;
  wire [39:0] route_in;
  wire [15:0] pad_in, pad_out, pad_oe_n, mc_route_out, inreg_route_out, pin_route_out;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;
  plt_logic_tile u_dut (.core_clk(core_clk), .arst_n(arst_n), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata_ff(cfg_rdata_ff),
    .route_in(route_in), .gclk(gclk), .g_set(g_set), .g_rst(g_rst), .goe(goe),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .mc_route_out(mc_route_out),
    .inreg_route_out(inreg_route_out), .pin_route_out(pin_route_out));
  plt_route_model u_far (.route_drv(rt), .pad_drv(pad_drv), .pad_out(pad_out),
    .pad_oe_n(pad_oe_n), .pin_route_out(pin_route_out), .route_in(route_in),
    .pad_in(pad_in));
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task end_of_test;
    if (err_total == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task chk1(input string n, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s exp %b got %b", n, e, g);
    end
  endtask
  task wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge core_clk);
    cfg_addr <= a;
    cfg_wdata <= d;
    cfg_wr <= 1'b1;
    @(posedge core_clk);
    cfg_wr <= 1'b0;
  endtask
  task rd(input logic [9:0] a, input logic [31:0] e);
    @(posedge core_clk);
    cfg_addr <= a;
    cfg_rd <= 1'b1;
    @(posedge core_clk);
    cfg_rd <= 1'b0;
    #1 chk("rdata", e, cfg_rdata_ff);
  endtask
  // one step of inputs and global clock 0, then macrocell 0 is judged
  task st(input logic [2:0] r, input logic c, input logic e);
    @(posedge core_clk);
    rt[2:0] <= r;
    gclk[0] <= c;
    @(posedge core_clk);
    #1 chk1("q", e, mc_route_out[0]);
  endtask
  task ctl(input logic s, input logic r, input logic e);
    @(posedge core_clk);
    g_set <= s;
    g_rst <= r;
    #1 chk1("q_forced", e, mc_route_out[0]);
  endtask
  task oe(input logic [2:0] r, input logic g, input logic e);
    @(posedge core_clk);
    rt[2:0] <= r;
    goe[0] <= g;
    #1 chk1("oe_n", e, pad_oe_n[0]);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task t_reset;
    chk("oe_n", 32'h0000FFFF, {16'h0, pad_oe_n});
    chk("route", 32'h0, {16'h0, mc_route_out});
    chk("pad", 32'h0, {16'h0, pad_out});
    rd(10'h140, 32'h0);
    rd(10'h161, 32'h0);
    wr(10'h003, 32'hFFFFFFFF);
    rd(10'h003, 32'h0);
    rd(10'h0E0, 32'h0);
    rd(10'h163, 32'hFFFFFFFF);
  endtask
  task t_comb;
    logic [15:0] e;
    wr(10'h000, 32'h0001_0000);
    wr(10'h005, 32'h0200_0000);
    wr(10'h0DC, 32'h0004_0000);
    for (int m = 0; m < 16; m++) wr(10'h100 + 10'(2 * m), 32'h1);
    wr(10'h102, 32'h3);
    wr(10'h103, 32'h0080_0000);
    wr(10'h144, 32'h01B8_0003);
    for (int v = 0; v < 8; v++) begin
      @(posedge core_clk) rt[2:0] <= 3'(v);
      #1;
      e = {16{v[0]}};
      e[1] = v[0] | !v[1] | v[2];
      e[2] = !(v[0] ^ v[2]);
      chk("sop", {16'h0, e}, {16'h0, mc_route_out});
      chk("pad", {16'h0, e}, {16'h0, pad_out});
      rd(10'h163, {30'h3FFFFFFF, !v[1], v[0]});
    end
  endtask
  task t_dff;
    wr(10'h140, 32'h0000_0104);
    st(3'h1, 1'b1, 1'b1);
    st(3'h0, 1'b1, 1'b1);
    st(3'h0, 1'b0, 1'b1);
    st(3'h0, 1'b1, 1'b0);
    wr(10'h140, 32'h0001_5104);
    ctl(1'b1, 1'b0, 1'b1);
    ctl(1'b0, 1'b0, 1'b1);
    ctl(1'b1, 1'b1, 1'b0);
    ctl(1'b0, 1'b0, 1'b0);
    wr(10'h141, 32'h00DC_0000);
    wr(10'h140, 32'h0001_5144);
    st(3'h1, 1'b0, 1'b0);
    st(3'h1, 1'b1, 1'b0);
    st(3'h5, 1'b0, 1'b0);
    st(3'h5, 1'b1, 1'b1);
    oe(3'h5, 1'b1, 1'b0);
    oe(3'h5, 1'b0, 1'b1);
    wr(10'h160, 32'h00DC_0000);
    wr(10'h140, 32'h0002_5144);
    oe(3'h5, 1'b0, 1'b0);
    oe(3'h1, 1'b0, 1'b1);
  endtask
  task t_tff;
    wr(10'h140, 32'h0000_4128);
    ctl(1'b0, 1'b1, 1'b0);
    ctl(1'b0, 1'b0, 1'b0);
    st(3'h1, 1'b0, 1'b1);
    st(3'h1, 1'b1, 1'b1);
    st(3'h1, 1'b0, 1'b0);
    st(3'h0, 1'b1, 1'b0);
    st(3'h0, 1'b0, 1'b0);
    wr(10'h140, 32'h0000_4118);
    st(3'h1, 1'b1, 1'b1);
    st(3'h1, 1'b0, 1'b0);
    st(3'h1, 1'b1, 1'b1);
  endtask
  task t_latch;
    wr(10'h140, 32'h0000_010C);
    st(3'h0, 1'b1, 1'b0);
    st(3'h1, 1'b1, 1'b1);
    st(3'h1, 1'b0, 1'b1);
    st(3'h0, 1'b0, 1'b1);
    wr(10'h140, 32'h0000_012C);
    st(3'h0, 1'b0, 1'b0);
  endtask
  task t_inreg;
    wr(10'h140, 32'h0000_0184);
    @(posedge core_clk);
    pad_drv[0] <= 1'b1;
    rt[2:0] <= 3'h0;
    repeat (6) @(posedge core_clk);
    gclk[0] <= 1'b1;
    @(posedge core_clk);
    #1 chk1("inreg", 1'b1, inreg_route_out[0]);
    chk1("buried", 1'b0, mc_route_out[0]);
    chk1("pin_oe_n", 1'b1, pad_oe_n[0]);
    chk1("pin_sync", 1'b1, pin_route_out[0]);
    @(posedge core_clk) rt[0] <= 1'b1;
    #1 chk1("buried", 1'b1, mc_route_out[0]);
    rd(10'h162, 32'h0001_0001);
  endtask
  // a hang is cut off far beyond the roughly 180 cycles the run needs
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      end_of_test;
    end
  end
  initial begin
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    t_reset;
    t_comb;
    t_dff;
    t_tff;
    t_latch;
    t_inreg;
    end_of_test;
  end
endmodule // plt_logic_tile_tb
